// ===== motor_err_pkg.sv
// Contract
// - Reverse command E0/60 plus magnitude byte
// - Zero magnitude sets awaiting flag, motor off
// - Nonzero clears awaiting; serial mode loads target
// - Analog/frequency feedback: 2048 minus 16*magnitude
// - No feedback: 2048 minus magnitude*600/127
// - Reports send low byte then high byte
// - Awaiting flag blocks drive, set at power-up in serial input mode only
// - Host attached, no supply raises bit 1
// - Driver fault raises bit 2, toggle recovery
// - Pulse input: four good pulses, 120 ms timeout
// - Input out of limits raises bit 4
// - Feedback out of limits raises bit 5
// - Current over limit raises bit 6
// - Missing stop bit raises bit 7
// - Overrun bit 8, buffer full bit 9
// - CRC mismatch discards packet, bit 10
// - Malformed packet raises bit 11
// - Serial timeout raises bit 12
// - Bits 13 to 15 read zero
// - Halting report returns enabled, clears but awaiting
// - Halting error other than awaiting lights red lamp, fault high
// - Occurred report returns record, then resets it
// - Addressed packet AA, device number, command
// - Motor-off FF sets awaiting flag
package motor_err_pkg;
  // Command bytes, compact framing
  localparam logic [7:0] CMD_ADDR = 8'hAA;
  localparam logic [7:0] CMD_REV_LOW = 8'hE0;
  localparam logic [7:0] CMD_OFF = 8'hFF;
  localparam logic [7:0] CMD_GET_HALT = 8'hB3;
  localparam logic [7:0] CMD_GET_OCC = 8'hB5;
  localparam logic [7:0] CMD_MSB = 8'h80;
  // Target arithmetic
  localparam logic [11:0] TARGET_MID = 12'h800;
  localparam int SPEED_SPAN = 600;
  localparam int MAG_MAX = 127;
  // Flag positions
  localparam int F_AWAIT = 0;
  localparam int F_NOPWR = 1;
  localparam int F_DRV = 2;
  localparam int F_INVAL = 3;
  localparam int F_INDISC = 4;
  localparam int F_FBDISC = 5;
  localparam int F_CURR = 6;
  localparam int F_FRAME = 7;
  localparam int F_OVR = 8;
  localparam int F_BUFF = 9;
  localparam int F_CRC = 10;
  localparam int F_PROTO = 11;
  localparam int F_TMO = 12;
  localparam logic [15:0] FLAG_USED = 16'h1FFF;
  // Input and feedback modes
  localparam logic [1:0] IN_SERIAL = 2'h0;
  localparam logic [1:0] IN_PULSE = 2'h2;
  localparam logic [1:0] FB_NONE = 2'h0;
  // Timing
  localparam int CLK_HZ = 200000000;
  localparam int INVALID_MS = 120;
  localparam int INVALID_CYC = CLK_HZ / 1000 * INVALID_MS;
  localparam int GOOD_PULSES = 4;
  localparam int RECOVER_CYC = 16;
endpackage : motor_err_pkg

// ===== motor_err_core.sv
`timescale 1ns/10ps
module motor_err_core
  import motor_err_pkg::*;
#(
  parameter int INVALID_CYCLES = INVALID_CYC,
  parameter logic [6:0] DEVICE_NUMBER = 7'h0B
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_NRST,
  // Received packet bytes from the UART
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_frame_err,
  input wire logic i_rx_overrun,
  input wire logic i_rx_buf_full,
  // CRC check on the finished packet
  input wire logic i_crc_en,
  input wire logic i_crc_ok,
  // Configuration
  input wire logic [1:0] i_input_mode,
  input wire logic [1:0] i_feedback_mode,
  input wire logic [15:0] i_err_enable,
  // Asynchronous fault pins
  input wire logic i_host_attached,
  input wire logic i_motor_supply_input,
  input wire logic i_driver_fault,
  // Same-domain condition strobes
  input wire logic i_pulse_good,
  input wire logic i_pulse_bad,
  input wire logic i_input_out_of_range,
  input wire logic i_feedback_out_of_range,
  input wire logic i_current_over,
  input wire logic i_serial_timeout,
  // Transmit side
  input wire logic i_tx_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  // Motor control outputs
  output logic [11:0] o_target,
  output logic o_target_load,
  output logic o_drive_enable,
  output logic o_driver_reset,
  output logic o_red_led,
  output logic o_fault
);
  // Elaboration check; a zero limit would flag stale input at once
  if (INVALID_CYCLES < 1) begin : g_bad_limit
    $error("INVALID_CYCLES must be positive");
  end

  // Pin synchronisers
  logic [2:0] sync1;
  logic [2:0] sync2;
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {i_driver_fault, i_motor_supply_input, i_host_attached};
      sync2 <= sync1;
    end
  end
  wire host_on = sync2[0];
  wire supply_on = sync2[1];
  wire drv_fault = sync2[2];

  // Packet parser states
  typedef enum logic [2:0] {S_IDLE, S_DEVNUM, S_ADDRCMD, S_DATA, S_CRC, S_SKIP} parse_e;
  parse_e state;
  logic [7:0] cmd; // Compact command held with top bit set
  logic [7:0] mag; // Held magnitude byte
  logic powered; // Power-up awaiting seed done

  // Byte classification
  wire is_cmd = i_rx_data[7];
  wire [7:0] as_cmd = i_rx_data | CMD_MSB;
  wire known = (as_cmd == CMD_REV_LOW) || (as_cmd == CMD_OFF)
    || (as_cmd == CMD_GET_HALT) || (as_cmd == CMD_GET_OCC);
  wire needs_data = (as_cmd == CMD_REV_LOW);
  wire new_cmd = i_rx_valid && is_cmd;
  // A command byte mid-packet aborts the old one
  wire interrupted = new_cmd && (state != S_IDLE) && (state != S_SKIP);
  wire bad_cmd_byte = i_rx_valid && (state == S_ADDRCMD) && !known;
  wire bad_compact = new_cmd && (i_rx_data != CMD_ADDR) && !known;
  wire stray_data = i_rx_valid && !is_cmd && (state == S_IDLE);
  wire proto_err = interrupted || bad_cmd_byte || bad_compact || stray_data;

  // Packet completion before CRC
  wire body_done = i_rx_valid && !is_cmd && (
    (state == S_DATA) ||
    (state == S_ADDRCMD && known && !needs_data)) ||
    (new_cmd && known && !needs_data);
  wire crc_done = i_rx_valid && !is_cmd && (state == S_CRC);
  // A fresh command byte wins over the one held from a cut packet
  wire [7:0] done_cmd = new_cmd ? i_rx_data :
    ((state == S_DATA || state == S_CRC) ? cmd : as_cmd);
  wire [7:0] done_mag = (state == S_DATA) ? i_rx_data : mag;
  wire exec = i_crc_en ? (crc_done && i_crc_ok) : body_done;
  wire crc_err = crc_done && !i_crc_ok;

  // Parser registers
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state <= S_IDLE;
      cmd <= 8'h00;
      mag <= 8'h00;
    end else if (i_rx_valid) begin
      unique case (state)
        S_IDLE, S_SKIP, S_DEVNUM, S_ADDRCMD, S_DATA, S_CRC: begin
          if (new_cmd) begin
            cmd <= i_rx_data;
            if (i_rx_data == CMD_ADDR) state <= S_DEVNUM;
            else if (!known) state <= S_IDLE;
            else if (needs_data) state <= S_DATA;
            else state <= i_crc_en ? S_CRC : S_IDLE;
          end else if (state == S_DEVNUM) begin
            // Other device numbers are skipped silently
            state <= (i_rx_data[6:0] == DEVICE_NUMBER) ? S_ADDRCMD : S_SKIP;
          end else if (state == S_ADDRCMD) begin
            cmd <= as_cmd;
            if (!known) state <= S_IDLE;
            else if (needs_data) state <= S_DATA;
            else state <= i_crc_en ? S_CRC : S_IDLE;
          end else if (state == S_DATA) begin
            mag <= i_rx_data;
            state <= i_crc_en ? S_CRC : S_IDLE;
          end else if (state == S_CRC) begin
            state <= S_IDLE;
          end
        end
      endcase
    end
  end

  // Decoded execution strobes
  wire do_rev = exec && (done_cmd == CMD_REV_LOW);
  wire do_off = exec && (done_cmd == CMD_OFF);
  wire do_halt = exec && (done_cmd == CMD_GET_HALT);
  wire do_occ = exec && (done_cmd == CMD_GET_OCC);
  wire [6:0] m7 = done_mag[6:0];
  wire rev_zero = do_rev && (m7 == 7'h00);
  wire rev_go = do_rev && (m7 != 7'h00);

  // Reverse target arithmetic
  wire [11:0] step16 = {1'b0, m7, 4'h0};
  wire [19:0] scaled = 20'(m7) * 20'(SPEED_SPAN) / 20'(MAG_MAX);
  wire [11:0] rev_target = (i_feedback_mode == FB_NONE) ?
    (TARGET_MID - scaled[11:0]) : (TARGET_MID - step16);

  // Pulse input qualification
  logic [2:0] good_run;
  logic [31:0] since_update;
  wire pulse_mode = (i_input_mode == IN_PULSE);
  wire pulse_update = pulse_mode && i_pulse_good && (good_run >= 3'(GOOD_PULSES - 1));
  wire input_invalid = pulse_mode && (since_update >= 32'(INVALID_CYCLES));
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      good_run <= 3'h0;
      since_update <= 32'h0;
    end else begin
      if (i_pulse_bad) good_run <= 3'h0;
      else if (i_pulse_good && good_run < 3'(GOOD_PULSES - 1)) good_run <= good_run + 3'h1;
      if (!pulse_mode || pulse_update) since_update <= 32'h0;
      else if (!input_invalid) since_update <= since_update + 32'h1;
    end
  end

  // Event vector from every source but the awaiting flag
  logic [15:0] events;
  always_comb begin
    events = 16'h0000;
    events[F_NOPWR] = host_on && !supply_on;
    events[F_DRV] = drv_fault || (host_on && !supply_on);
    events[F_INVAL] = input_invalid;
    events[F_INDISC] = i_input_out_of_range;
    events[F_FBDISC] = i_feedback_out_of_range;
    events[F_CURR] = i_current_over;
    events[F_FRAME] = i_rx_valid && i_rx_frame_err;
    events[F_OVR] = i_rx_overrun;
    events[F_BUFF] = i_rx_buf_full;
    events[F_CRC] = crc_err;
    events[F_PROTO] = proto_err;
    events[F_TMO] = i_serial_timeout;
  end

  // Flag words
  logic awaiting;
  logic [15:0] halt_latch;
  logic [15:0] occurred;
  // Power-up seed only in serial input mode, so the record stays clean otherwise
  wire await_set = rev_zero || do_off || (!powered && (i_input_mode == IN_SERIAL));
  wire await_clr = rev_go;
  wire next_awaiting = await_set ? 1'b1 : (await_clr ? 1'b0 : awaiting);
  wire [15:0] await_vec = {15'h0, next_awaiting};
  wire [15:0] halt_view = ({halt_latch[15:1], awaiting}) & i_err_enable & FLAG_USED;
  wire [15:0] occ_view = occurred & FLAG_USED;
  // Set wins over clear in both words
  wire [15:0] next_halt = (do_halt ? 16'h0000 : halt_latch) | events;
  wire [15:0] next_occ = (do_occ ? 16'h0000 : occurred) | events | await_vec;
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      powered <= 1'b0;
      awaiting <= 1'b0;
      halt_latch <= 16'h0000;
      occurred <= 16'h0000;
    end else begin
      // Seed and commands both arrive through next_awaiting
      powered <= 1'b1;
      awaiting <= next_awaiting;
      halt_latch <= next_halt;
      occurred <= next_occ;
    end
  end

  // Target load
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      o_target <= TARGET_MID;
      o_target_load <= 1'b0;
    end else begin
      o_target_load <= rev_go && (i_input_mode == IN_SERIAL);
      if (rev_go && i_input_mode == IN_SERIAL) o_target <= rev_target;
    end
  end

  // Two-byte response, low byte first
  logic [7:0] tx_hi;
  logic tx_second;
  wire start_resp = do_halt || do_occ;
  wire [15:0] resp_word = do_halt ? halt_view : occ_view;
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      o_tx_valid <= 1'b0;
      o_tx_data <= 8'h00;
      tx_hi <= 8'h00;
      tx_second <= 1'b0;
    end else if (start_resp) begin
      // A new request restarts the reply
      o_tx_valid <= 1'b1;
      o_tx_data <= resp_word[7:0];
      tx_hi <= resp_word[15:8];
      tx_second <= 1'b1;
    end else if (o_tx_valid && i_tx_ready) begin
      o_tx_valid <= tx_second;
      o_tx_data <= tx_hi;
      tx_second <= 1'b0;
    end
  end

  // Driver recovery pulse
  logic [4:0] recover;
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      recover <= 5'h00;
    end else if (drv_fault && recover == 5'h00) begin
      recover <= 5'(RECOVER_CYC);
    end else if (recover != 5'h00) begin
      recover <= recover - 5'h01;
    end
  end

  // Motor gating and indicators
  wire halting_other = |(halt_view[15:1]);
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      o_drive_enable <= 1'b0;
      o_driver_reset <= 1'b0;
      o_red_led <= 1'b0;
      o_fault <= 1'b0;
    end else begin
      o_drive_enable <= !awaiting && !halting_other;
      o_driver_reset <= (recover != 5'h00);
      o_red_led <= halting_other;
      o_fault <= halting_other;
    end
  end
endmodule : motor_err_core

// ===== motor_err_asserts.sv
`timescale 1ns/10ps
module motor_err_asserts
  import motor_err_pkg::*;
(
  // Watched ports
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_frame_err,
  input wire logic i_crc_en,
  input wire logic [1:0] i_input_mode,
  input wire logic [1:0] i_feedback_mode,
  input wire logic [15:0] i_err_enable,
  input wire logic i_tx_ready,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic [11:0] o_target,
  input wire logic o_target_load,
  input wire logic o_drive_enable,
  input wire logic o_red_led,
  input wire logic o_fault
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  logic hi; // High reply byte is next
  wire rpt = i_rx_valid && (i_rx_data == CMD_GET_OCC || i_rx_data == CMD_GET_HALT);
  // Byte phase; a new report restarts at the low byte
  always_ff @(posedge I_CLK or negedge I_NRST)
    if (!I_NRST) hi <= 1'b0;
    else if (rpt) hi <= 1'b0;
    else if (o_tx_valid && i_tx_ready) hi <= !hi;
  sequence s_rev;
    i_rx_valid && i_rx_data == CMD_REV_LOW && !i_crc_en && !i_rx_frame_err;
  endsequence
  sequence s_mag;
    i_rx_valid && !i_rx_data[7] && !i_rx_frame_err && i_input_mode == IN_SERIAL;
  endsequence
  AST_FB_TARGET: assert property (s_rev ##1 s_mag ##0 (i_rx_data != 8'h00 &&
    i_feedback_mode != FB_NONE) |=> o_target_load &&
    o_target == 12'h800 - {1'b0, $past(i_rx_data[6:0]), 4'h0}) else $error("fb target");
  AST_SPD_TARGET: assert property (s_rev ##1 s_mag ##0 (i_rx_data != 8'h00 &&
    i_feedback_mode == FB_NONE) |=> o_target_load && o_target ==
    12'(2048 - int'($past(i_rx_data[6:0])) * SPEED_SPAN / MAG_MAX)) else $error("spd target");
  AST_ZERO_MAG: assert property (s_rev ##1 s_mag ##0 (i_rx_data == 8'h00)
    |=> !o_target_load ##1 !o_drive_enable) else $error("zero magnitude drove");
  AST_LOAD_BELOW: assert property (o_target_load |-> o_target < TARGET_MID)
    else $error("target not below mid");
  AST_LOAD_GAP: assert property (o_target_load |=> !o_target_load)
    else $error("load twice");
  AST_LED_FAULT: assert property (o_red_led == o_fault &&
    (!o_fault || $past(i_err_enable[12:1] != 12'h000))) else $error("led fault");
  AST_DRIVE_FAULT: assert property (o_fault |-> !o_drive_enable)
    else $error("drive with fault");
  AST_TX_HOLD: assert property (o_tx_valid && !i_tx_ready && !i_rx_valid
    |=> o_tx_valid && $stable(o_tx_data)) else $error("reply not held");
  sequence s_rpt;
    i_rx_valid && (i_rx_data == CMD_GET_OCC || i_rx_data == CMD_GET_HALT) && !i_crc_en;
  endsequence
  AST_RPT_ANSWER: assert property (s_rpt |=> o_tx_valid)
    else $error("no reply");
  AST_RSV_ZERO: assert property (o_tx_valid && hi |-> o_tx_data[7:5] == 3'h0)
    else $error("reserved set");
  AST_TWO_BYTES: assert property (o_tx_valid && i_tx_ready && hi && !i_rx_valid
    |=> !o_tx_valid) else $error("reply too long");
endmodule : motor_err_asserts
bind motor_err_core motor_err_asserts u_chk (.I_CLK, .I_NRST, .i_rx_valid, .i_rx_data,
  .i_rx_frame_err, .i_crc_en, .i_input_mode, .i_feedback_mode, .i_err_enable, .i_tx_ready,
  .o_tx_valid,
  .o_tx_data, .o_target, .o_target_load, .o_drive_enable, .o_red_led, .o_fault);

// ===== host_link.sv
`timescale 1ns/10ps
module host_link (
  // Clock and reply side
  input wire logic clk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic slow,
  // Command side
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready
);
  logic [7:0] got[$]; // Reply bytes taken
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end
  // Whole packet, valid held between bytes
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      rx_valid = 1'b1;
      rx_data = q[i];
      @(posedge clk);
      #1;
    end
    rx_valid = 1'b0;
    rx_data = ~rx_data; // Idle line never repeats a byte
  endtask : send
  // Slow mode stalls every other cycle
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    #1 tx_ready = !slow || !tx_ready;
  end
endmodule : host_link

// ===== motor_error_flag_reporting_test.sv
`timescale 1ns/10ps
module motor_error_flag_reporting_test;
  import motor_err_pkg::*;
  localparam logic [7:0] DEV = 8'h0B; // Default device number
  // Pins, named as the ports
  logic I_CLK, I_NRST, i_rx_valid, i_rx_frame_err, i_rx_overrun, i_rx_buf_full, i_crc_en;
  logic i_crc_ok, i_host_attached, i_motor_supply_input, i_driver_fault, i_pulse_good;
  logic i_pulse_bad, i_input_out_of_range, i_feedback_out_of_range, i_current_over;
  logic i_serial_timeout, i_tx_ready, o_tx_valid, o_target_load, o_drive_enable;
  logic o_driver_reset, o_red_led, o_fault, slow;
  logic [7:0] i_rx_data, o_tx_data, m;
  logic [1:0] i_input_mode, i_feedback_mode;
  logic [15:0] i_err_enable, w;
  logic [11:0] o_target, t0;
  int num_errors, n_checks, seed;
  int flag_bit[12] = '{6, 4, 5, 12, 8, 9, 7, 11, 11, 10, 1, 2}; // Flag per event
  motor_err_core #(.INVALID_CYCLES(50)) u_dut (
    .I_CLK, .I_NRST, .i_rx_valid, .i_rx_data, .i_rx_frame_err, .i_rx_overrun, .i_rx_buf_full,
    .i_crc_en, .i_crc_ok, .i_input_mode, .i_feedback_mode, .i_err_enable, .i_host_attached,
    .i_motor_supply_input, .i_driver_fault, .i_pulse_good, .i_pulse_bad, .i_input_out_of_range,
    .i_feedback_out_of_range, .i_current_over, .i_serial_timeout, .i_tx_ready, .o_tx_valid,
    .o_tx_data, .o_target, .o_target_load, .o_drive_enable, .o_driver_reset, .o_red_led, .o_fault
  );
  host_link u_host (.clk(I_CLK), .tx_valid(o_tx_valid), .tx_data(o_tx_data), .slow(slow),
    .rx_valid(i_rx_valid), .rx_data(i_rx_data), .tx_ready(i_tx_ready));
  initial begin
    I_CLK = 1'b0;
    forever #2.5 I_CLK = ~I_CLK;
  end
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge I_CLK);
      #1;
    end
  endtask : tick
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // Expected reverse target, truncating like the device
  function automatic logic [11:0] exp_tgt(input logic [1:0] fb, input int mg);
    return (fb == FB_NONE) ? 12'(2048 - mg * SPEED_SPAN / MAG_MAX) : 12'(2048 - 16 * mg);
  endfunction : exp_tgt
  // Compact or addressed packet, CRC byte when enabled
  task automatic cmd(input logic [7:0] c, input int n, input logic [7:0] d, input bit adr);
    logic [7:0] q[$];
    if (adr) q = {CMD_ADDR, DEV, c & 8'h7F};
    else q = {c};
    if (n > 0) q.push_back(d);
    if (i_crc_en) q.push_back(8'h00);
    u_host.send(q);
  endtask : cmd
  task automatic rd(input logic [7:0] c, input bit adr);
    u_host.got.delete();
    cmd(c, 0, 8'h00, adr);
    for (int i = 0; i < 40 && u_host.got.size() < 2; i++) tick(1);
    w = (u_host.got.size() >= 2) ? {u_host.got[1], u_host.got[0]} : 16'hXXXX;
    chk(16'(w[15:13]), 16'h0000);
  endtask : rd
  task automatic rev(input logic [7:0] mg, input bit adr);
    cmd(CMD_REV_LOW, 1, mg, adr);
    for (int k = 0; k < 4 && o_target_load !== 1'b1; k++) tick(1);
    chk({o_target_load, 3'h0, o_target}, {4'h8, exp_tgt(i_feedback_mode, mg[6:0])});
    tick(1); // Let an edge pass before the next packet
  endtask : rev
  // Motor-off style command, then recover
  task automatic off_chk(input logic [7:0] c, input int n);
    cmd(c, n, 8'h00, 1'b0);
    tick(3);
    chk(16'(o_drive_enable), 16'h0000);
    rd(CMD_GET_OCC, 1'b0);
    chk(w & 16'h0001, 16'h0001);
    rev(8'h33, 1'b1);
    tick(3);
    chk(16'(o_drive_enable), 16'h0001);
  endtask : off_chk
  // One error event held a few cycles; tail covers the pin lag
  task automatic ev(input int k);
    i_rx_frame_err = (k == 6);
    i_crc_en = (k == 9);
    i_crc_ok = (k != 9);
    case (k)
      0: i_current_over = 1'b1;
      1: i_input_out_of_range = 1'b1;
      2: i_feedback_out_of_range = 1'b1;
      3: i_serial_timeout = 1'b1;
      4: i_rx_overrun = 1'b1;
      5: i_rx_buf_full = 1'b1;
      6, 8: cmd(8'h12, 0, 8'h00, 1'b0);
      7: cmd(8'hF0, 0, 8'h00, 1'b0);
      9: cmd(CMD_REV_LOW, 1, 8'h10, 1'b0);
      10: {i_host_attached, i_motor_supply_input} = 2'h2;
      default: i_driver_fault = 1'b1;
    endcase
    tick(6);
    {i_rx_frame_err, i_crc_en, i_current_over, i_input_out_of_range} = '0;
    {i_feedback_out_of_range, i_serial_timeout, i_rx_overrun, i_rx_buf_full} = '0;
    {i_host_attached, i_driver_fault, i_motor_supply_input, i_crc_ok} = 4'h3;
    tick(4);
  endtask : ev
  initial begin
    seed = 76163;
    {i_rx_frame_err, i_rx_overrun, i_rx_buf_full, i_crc_en, i_host_attached} = '0;
    {i_driver_fault, i_pulse_good, i_pulse_bad, i_input_out_of_range} = '0;
    {i_feedback_out_of_range, i_current_over, i_serial_timeout, slow, I_NRST} = '0;
    {i_crc_ok, i_motor_supply_input} = 2'h3;
    i_input_mode = IN_SERIAL;
    i_feedback_mode = 2'h1;
    i_err_enable = 16'h0000;
    repeat (5) @(posedge I_CLK);
    #1 I_NRST = 1'b1;
    tick(2);
    rd(CMD_GET_OCC, 1'b0);
    chk(w, 16'h0001);
    chk(16'(o_drive_enable), 16'h0000);
    // Random reverse targets, corners first
    for (int i = 0; i < 10; i++) begin
      i_feedback_mode = 2'($random(seed));
      slow = 1'($random(seed));
      m = (i == 0) ? 8'h7F : (i == 1) ? 8'h01 : ({1'b0, 7'($random(seed))} | 8'h01);
      rev(m, 1'($random(seed)));
    end
    tick(3);
    chk(16'(o_drive_enable), 16'h0001);
    // Addressed packet for another device is skipped quietly
    rd(CMD_GET_OCC, 1'b0);
    t0 = o_target;
    u_host.send('{CMD_ADDR, DEV + 8'h01, 8'h60, 8'h10});
    tick(3);
    chk(16'(o_target), 16'(t0));
    rd(CMD_GET_OCC, 1'b0);
    chk(w, 16'h0000);
    off_chk(CMD_REV_LOW, 1);
    off_chk(CMD_OFF, 0);
    t0 = o_target;
    for (int k = 0; k < 12; k++) begin
      slow = k[1];
      ev(k);
      chk(16'(o_driver_reset), 16'(k == 11));
      rd(CMD_GET_OCC, k[0]);
      chk(w & (16'h1 << flag_bit[k]), 16'h1 << flag_bit[k]);
      rd(CMD_GET_OCC, 1'b0);
      chk(w, 16'h0000);
    end
    chk(16'(o_target), 16'(t0));
    i_err_enable = 16'h0040;
    ev(0);
    chk({13'h0, o_fault, o_red_led, o_drive_enable}, 16'h0006);
    rd(CMD_GET_HALT, 1'b1);
    chk(w, 16'h0040);
    tick(2);
    chk({13'h0, o_fault, o_red_led, o_drive_enable}, 16'h0001);
    // Pulse input: no serial target, stale input flagged
    i_input_mode = IN_PULSE;
    cmd(CMD_REV_LOW, 1, 8'h20, 1'b0);
    for (int i = 0; i < 4; i++) begin
      chk(16'(o_target_load), 16'h0000);
      tick(1);
    end
    tick(60);
    rd(CMD_GET_OCC, 1'b0);
    chk(w & 16'h0008, 16'h0008);
    // Three good, a bad one, three good: still stale
    {i_pulse_good, i_pulse_bad} = 2'h2;
    tick(3);
    {i_pulse_good, i_pulse_bad} = 2'h1;
    tick(1);
    {i_pulse_good, i_pulse_bad} = 2'h2;
    tick(3);
    {i_pulse_good, i_pulse_bad} = 2'h0;
    rd(CMD_GET_OCC, 1'b0);
    rd(CMD_GET_OCC, 1'b0);
    chk(w & 16'h0008, 16'h0008);
    // Fourth good pulse in a row updates the input
    i_pulse_good = 1'b1;
    tick(1);
    i_pulse_good = 1'b0;
    rd(CMD_GET_OCC, 1'b0);
    rd(CMD_GET_OCC, 1'b0);
    chk(w, 16'h0000);
    end_of_test();
  end
  // Watchdog: whole run needs only a few hundred cycles
  initial begin
    #200000;
    num_errors++;
    end_of_test();
  end
endmodule : motor_error_flag_reporting_test
